//--- bwc_defs.svh
// register offsets, field positions, masks and reload values
`ifndef BWC_DEFS_SVH
`define BWC_DEFS_SVH
`define BWC_ADDR_BUS1 7'h04
`define BWC_ADDR_BUS2 7'h05
`define BWC_ADDR_WAKE 7'h06
`define BWC_RESET_VAL 8'h00
`define BWC_READ_NONE 8'h00
`define BWC_BUS1_WMASK 8'hFB
`define BWC_BUS2_WMASK 8'h23
`define BWC_WAKE_WMASK 8'hC4
`define BWC_BUS1_FS_KEEP 8'hE0
`define BWC_BUS1_FS_SET 8'h09
`define BWC_BUS2_FS_VAL 8'h01
`define BWC_BUS2_RS_KEEP 8'h23
`define BWC_WAKE_RS_KEEP 8'hC0
`define BWC_BIT_FLASH 7
`define BWC_BIT_LSM 6
`define BWC_BIT_TXDTO 5
`define BWC_LSB_FIRST_LIN_MODE 3
`define BWC_LSB_CAN 0
`define BWC_BIT_PEAK 5
`define BWC_LSB_SECOND_LIN_MODE 0
`define BWC_BIT_T2WK 7
`define BWC_BIT_T1WK 6
`define BWC_BIT_WDOFF 2
`define BWC_FRAME_BITS 16
`define BWC_ADDR_BITS 8
`define BWC_CNT_W 5
`endif

//--- bwc_pkg.sv
// shared types of the bus and wake control registers
package bwc_pkg;
    // operating mode of the chip as reported by the mode logic
    typedef enum logic [2:0] {
        BWC_INIT, BWC_NORMAL, BWC_STOP, BWC_SLEEP, BWC_RESTART, BWC_FAILSAFE
    } bwc_sbc_mode_t;
    // one SPI frame: write flag, address, data
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } bwc_frame_t;
    // decoded transceiver mode, one-hot
    typedef struct packed {
        logic off;
        logic wake;
        logic rx_only;
        logic normal;
    } bwc_xcvr_t;
    // hardware-owned fields pushed by the mode logic
    typedef struct packed {
        logic [1:0] can_mode;
        logic [1:0] first_lin_mode;
        logic [1:0] second_lin_mode;
        logic stop_watchdog_off_hi;
    } bwc_hw_upd_t;
endpackage : bwc_pkg

//--- bwc_mode_decode.sv
// decodes one 2-bit transceiver mode field into one-hot flags
`timescale 1ns/1ps
`include "bwc_defs.svh"
module bwc_mode_decode
    import bwc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [1:0] field,
    output bwc_xcvr_t mode_q
);
    // 00 off, 01 wake capable, 10 receive only, 11 normal
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= 4'h8;
        end else begin
            mode_q.off <= (field == 2'h0);
            mode_q.wake <= (field == 2'h1);
            mode_q.rx_only <= (field == 2'h2);
            mode_q.normal <= (field == 2'h3);
        end
    end
endmodule : bwc_mode_decode

//--- bwc_spi_slave.sv
// SPI frame receiver with read-data return, pins synchronised
`timescale 1ns/1ps
`include "bwc_defs.svh"
module bwc_spi_slave
    import bwc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic chip_select_n,
    input wire logic spi_clk,
    input wire logic spi_mosi,
    input wire logic [7:0] rd_data,
    output bwc_frame_t frame_q,
    output logic frame_done_q,
    output logic spi_miso_q,
    output logic spi_miso_oe_n_q
);
    logic [2:0] cs_q, ck_q, di_q;
    logic [`BWC_CNT_W-1:0] cnt_q;
    logic [7:0] tx_q;
    // two flops per pin; the third stage only feeds edge detection
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_q <= 3'h7;
            ck_q <= 3'h0;
            di_q <= 3'h0;
        end else begin
            cs_q <= {cs_q[1:0], chip_select_n};
            ck_q <= {ck_q[1:0], spi_clk};
            di_q <= {di_q[1:0], spi_mosi};
        end
    end
    // shift on rising clock, msb first; count saturates past a frame
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_q <= '0;
            cnt_q <= '0;
        end else if (cs_q[1]) begin
            cnt_q <= '0;
        end else if (ck_q[1] && !ck_q[2]) begin
            frame_q <= {frame_q[`BWC_FRAME_BITS-2:0], di_q[1]};
            if (cnt_q != `BWC_CNT_W'(`BWC_FRAME_BITS + 1))
                cnt_q <= cnt_q + 1'b1;
        end
    end
    // read data latched once the address byte is complete
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_q <= `BWC_READ_NONE;
        end else if (cnt_q == `BWC_CNT_W'(`BWC_ADDR_BITS)) begin
            tx_q <= rd_data;
        end
    end
    // data byte driven out on falling clock; a frame of wrong length is dropped
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            spi_miso_q <= 1'b0;
            spi_miso_oe_n_q <= 1'b1;
            frame_done_q <= 1'b0;
        end else begin
            spi_miso_oe_n_q <= cs_q[1];
            if (!ck_q[1] && ck_q[2] && cnt_q[3])
                spi_miso_q <= tx_q[~cnt_q[2:0]];
            frame_done_q <= cs_q[1] && !cs_q[2]
                && (cnt_q == `BWC_CNT_W'(`BWC_FRAME_BITS));
        end
    end
endmodule : bwc_spi_slave

//--- bwc_regs.sv
// bus and wake control registers of the system basis chip
//
// What this block does
// - flash bit 7 set disables LIN slope control
// - low-slope bit selects 10.4kBaud slow slopes
// - bit 5 enables LIN transmit time-out
// - first LIN mode bits 4:3 decoded
// - CAN mode bits 1:0 decoded
// - second LIN mode bits 1:0 decoded
// - LIN options apply at frame end, both transceivers
// - fail-safe entry reloads wake-capable values
// - peak bit writable only in init, normal
// - stop mode ignores peak writes, no error
// - peak bit selects low or high threshold
// - bit 7 arms second cyclic timer wake
// - bit 6 arms first cyclic timer wake
// - bit 2 switches watchdog off in stop
// - reserved bits read zero, never written
// - mode logic may load transceiver mode fields
// - restart clears low wake-register bits, keeps top
`timescale 1ns/1ps
`include "bwc_defs.svh"
module bwc_regs
    import bwc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic chip_select_n,
    input wire logic spi_clk,
    input wire logic spi_mosi,
    output logic spi_miso_q,
    output logic spi_miso_oe_n_q,
    input bwc_sbc_mode_t sbc_mode,
    input wire logic soft_reset,
    input wire logic failsafe_entry,
    input wire logic restart_entry,
    input wire logic hw_load,
    input bwc_hw_upd_t hw_upd,
    output bwc_xcvr_t can_mode_q,
    output bwc_xcvr_t first_lin_mode_q,
    output bwc_xcvr_t second_lin_mode_q,
    output logic slope_control_on_q,
    output logic low_slope_select_q,
    output logic transmit_timeout_enable_q,
    output logic peak_threshold_high_q,
    output logic timer_one_wake_enable_q,
    output logic timer_two_wake_enable_q,
    output logic stop_watchdog_off_hi_q,
    output logic ext_wake_failsafe_q
);
    logic [7:0] bus1_q;
    logic [7:0] bus2_q;
    logic [7:0] wake_q;
    logic [7:0] rd_data;
    logic [7:0] bus2_wmask;
    bwc_frame_t frame;
    logic frame_done;
    logic wr_bus1, wr_bus2, wr_wake;
    logic peak_writable;

    bwc_spi_slave u_spi (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .chip_select_n(chip_select_n),
        .spi_clk(spi_clk),
        .spi_mosi(spi_mosi),
        .rd_data(rd_data),
        .frame_q(frame),
        .frame_done_q(frame_done),
        .spi_miso_q(spi_miso_q),
        .spi_miso_oe_n_q(spi_miso_oe_n_q)
    );

    // write strobes for the three mapped addresses; others are ignored here
    assign wr_bus1 = frame_done && frame.wr
        && (frame.addr == `BWC_ADDR_BUS1);
    assign wr_bus2 = frame_done && frame.wr
        && (frame.addr == `BWC_ADDR_BUS2);
    assign wr_wake = frame_done && frame.wr
        && (frame.addr == `BWC_ADDR_WAKE);

    assign peak_writable = (sbc_mode == BWC_INIT) || (sbc_mode == BWC_NORMAL);
    // stop mode masks the bit quietly
    // the write simply drops the bit; no failure flag exists to raise
    assign bus2_wmask = peak_writable ? `BWC_BUS2_WMASK
        : (`BWC_BUS2_WMASK & ~(8'h01 << `BWC_BIT_PEAK));

    // reserved bits read zero
    // stored bits outside the write masks are never set, so reads are clean
    // read data is latched after eight bits, while the address byte still
    // sits in the low half of the shifter, so decode that half
    always_comb begin
        rd_data = `BWC_READ_NONE;
        unique case (frame.data[6:0])
            `BWC_ADDR_BUS1: rd_data = bus1_q & `BWC_BUS1_WMASK;
            `BWC_ADDR_BUS2: rd_data = bus2_q & `BWC_BUS2_WMASK;
            `BWC_ADDR_WAKE: rd_data = wake_q & `BWC_WAKE_WMASK;
            default: rd_data = `BWC_READ_NONE;
        endcase
    end

    // first bus control register; priority soft reset, fail-safe, mode logic,
    // then SPI write; restart does not touch it
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus1_q <= `BWC_RESET_VAL;
        end else if (soft_reset) begin
            bus1_q <= `BWC_RESET_VAL;
        end else if (failsafe_entry) begin
            bus1_q <= (bus1_q & `BWC_BUS1_FS_KEEP) | `BWC_BUS1_FS_SET;
        end else if (hw_load) begin
            bus1_q[`BWC_LSB_CAN +: 2] <= hw_upd.can_mode;
            bus1_q[`BWC_LSB_FIRST_LIN_MODE +: 2] <= hw_upd.first_lin_mode;
        end else if (wr_bus1) begin
            bus1_q <= frame.data & `BWC_BUS1_WMASK;
        end
    end

    // second bus control register; restart clears the reserved bits only
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus2_q <= `BWC_RESET_VAL;
        end else if (soft_reset) begin
            bus2_q <= `BWC_RESET_VAL;
        end else if (failsafe_entry) begin
            bus2_q <= `BWC_BUS2_FS_VAL;
        end else if (restart_entry) begin
            bus2_q <= bus2_q & `BWC_BUS2_RS_KEEP;
        end else if (hw_load) begin
            bus2_q[`BWC_LSB_SECOND_LIN_MODE +: 2] <= hw_upd.second_lin_mode;
        end else if (wr_bus2) begin
            bus2_q <= (bus2_q & ~bus2_wmask) | (frame.data & bus2_wmask);
        end
    end

    // internal wake register; fail-safe leaves it alone
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_q <= `BWC_RESET_VAL;
        end else if (soft_reset) begin
            wake_q <= `BWC_RESET_VAL;
        end else if (restart_entry) begin
            wake_q <= wake_q & `BWC_WAKE_RS_KEEP;
        end else if (hw_load) begin
            wake_q[`BWC_BIT_WDOFF] <= hw_upd.stop_watchdog_off_hi;
        end else if (wr_wake) begin
            wake_q <= frame.data & `BWC_WAKE_WMASK;
        end
    end

    bwc_mode_decode u_can (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .field(bus1_q[`BWC_LSB_CAN +: 2]),
        .mode_q(can_mode_q)
    );

    bwc_mode_decode u_first_lin_mode (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .field(bus1_q[`BWC_LSB_FIRST_LIN_MODE +: 2]),
        .mode_q(first_lin_mode_q)
    );

    bwc_mode_decode u_second_lin_mode (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .field(bus2_q[`BWC_LSB_SECOND_LIN_MODE +: 2]),
        .mode_q(second_lin_mode_q)
    );

    // shared LIN options, one cycle after the register changes
    // both LINs, at frame end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            slope_control_on_q <= 1'b1;
            low_slope_select_q <= 1'b0;
            transmit_timeout_enable_q <= 1'b0;
        end else begin
            slope_control_on_q <= !bus1_q[`BWC_BIT_FLASH];
            low_slope_select_q <= bus1_q[`BWC_BIT_LSM];
            transmit_timeout_enable_q <= bus1_q[`BWC_BIT_TXDTO];
        end
    end

    // supply and wake source controls
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            peak_threshold_high_q <= 1'b0;
            timer_one_wake_enable_q <= 1'b0;
            timer_two_wake_enable_q <= 1'b0;
            stop_watchdog_off_hi_q <= 1'b0;
        end else begin
            peak_threshold_high_q <= bus2_q[`BWC_BIT_PEAK];
            timer_one_wake_enable_q <= wake_q[`BWC_BIT_T1WK];
            timer_two_wake_enable_q <= wake_q[`BWC_BIT_T2WK];
            stop_watchdog_off_hi_q <= wake_q[`BWC_BIT_WDOFF];
        end
    end

    // tells the external wake register to take its fail-safe value too
    // external wake reload strobe
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_wake_failsafe_q <= 1'b0;
        end else begin
            ext_wake_failsafe_q <= failsafe_entry && !soft_reset;
        end
    end

    // checks kept beside the logic

    a_flash_slope: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(bus1_q[`BWC_BIT_FLASH]) |=> !slope_control_on_q
    ) else $error("flash bit did not turn slope control off");

    a_lsm_follow: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        $changed(bus1_q[`BWC_BIT_LSM])
            |=> low_slope_select_q == $past(bus1_q[`BWC_BIT_LSM])
    ) else $error("low-slope output does not follow its bit");

    a_txdto_follow: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ##1 transmit_timeout_enable_q == $past(bus1_q[`BWC_BIT_TXDTO])
    ) else $error("time-out enable does not follow its bit");

    a_can_decode: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        bus1_q[1:0] == 2'h1 |=> can_mode_q.wake && !can_mode_q.normal
    ) else $error("CAN wake capable not decoded");

    a_first_lin_mode_decode: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        bus1_q[4:3] == 2'h3 |=> first_lin_mode_q.normal
    ) else $error("first LIN normal not decoded");

    a_second_lin_mode_decode: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        bus2_q[1:0] == 2'h2 |=> second_lin_mode_q.rx_only
    ) else $error("second LIN receive only not decoded");

    a_frame_apply: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        wr_bus1 && !soft_reset && !failsafe_entry && !hw_load
            |=> bus1_q[7:5] == $past(frame.data[7:5])
            ##1 low_slope_select_q == bus1_q[`BWC_BIT_LSM]
    ) else $error("LIN option write not applied at frame end");

    a_failsafe_load: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        failsafe_entry && !soft_reset
            |=> bus1_q[4:0] == 5'h09 && bus2_q == 8'h01
            && ext_wake_failsafe_q && bus1_q[7:5] == $past(bus1_q[7:5])
    ) else $error("fail-safe reload values wrong");

    a_peak_stop: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        wr_bus2 && sbc_mode == BWC_STOP && !soft_reset && !failsafe_entry
            && !restart_entry
            |=> $stable(bus2_q[`BWC_BIT_PEAK])
    ) else $error("peak bit changed by a write in stop mode");

    a_peak_normal: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        wr_bus2 && sbc_mode == BWC_NORMAL && !soft_reset && !failsafe_entry
            && !restart_entry && !hw_load
            |=> bus2_q[`BWC_BIT_PEAK] == $past(frame.data[`BWC_BIT_PEAK])
            ##1 peak_threshold_high_q == bus2_q[`BWC_BIT_PEAK]
    ) else $error("peak bit write in normal mode lost");

    a_timer_wake: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ##1 timer_two_wake_enable_q == $past(wake_q[`BWC_BIT_T2WK])
            && timer_one_wake_enable_q == $past(wake_q[`BWC_BIT_T1WK])
    ) else $error("timer wake enables do not follow their bits");

    a_reserved_zero: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (bus1_q & ~`BWC_BUS1_WMASK) == 8'h00
            && (bus2_q & ~`BWC_BUS2_WMASK) == 8'h00
            && (wake_q & ~`BWC_WAKE_WMASK) == 8'h00
    ) else $error("reserved bit set");

    a_restart_wake: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        restart_entry && !soft_reset
            |=> wake_q[5:0] == 6'h00 && wake_q[7:6] == $past(wake_q[7:6])
    ) else $error("restart reload of wake register wrong");

    a_soft_clear: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        soft_reset |=> bus1_q == 8'h00 && bus2_q == 8'h00
            && wake_q == 8'h00 ##1 stop_watchdog_off_hi_q == 1'b0
    ) else $error("soft reset did not clear the registers");

    a_hw_load: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        hw_load && !soft_reset && !failsafe_entry && !restart_entry
            |=> bus1_q[1:0] == $past(hw_upd.can_mode)
            && bus2_q[1:0] == $past(hw_upd.second_lin_mode)
    ) else $error("mode logic load of transceiver fields lost");

    a_peak_init: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        wr_bus2 && sbc_mode == BWC_INIT && !soft_reset && !failsafe_entry
            && !restart_entry && !hw_load
            |=> bus2_q[`BWC_BIT_PEAK] == $past(frame.data[`BWC_BIT_PEAK])
    ) else $error("peak bit write in init mode lost");

    a_wdoff_follow: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ##1 stop_watchdog_off_hi_q == $past(wake_q[`BWC_BIT_WDOFF])
    ) else $error("watchdog stop-mode output does not follow its bit");

    a_hwload_first_lin_mode: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        hw_load && !soft_reset && !failsafe_entry && !restart_entry
            |=> bus1_q[`BWC_LSB_FIRST_LIN_MODE +: 2] == $past(hw_upd.first_lin_mode)
            && wake_q[`BWC_BIT_WDOFF] == $past(hw_upd.stop_watchdog_off_hi)
    ) else $error("mode logic load of first LIN or watchdog bit lost");

    a_can_rxonly: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        bus1_q[`BWC_LSB_CAN +: 2] == 2'h2 |=> can_mode_q.rx_only
    ) else $error("CAN receive only not decoded");

endmodule : bwc_regs

//--- bwc_spi_master.sv
// SPI master model standing in for the microcontroller
`timescale 1ns/1ps
module bwc_spi_master (
    input wire logic ref_clk,
    output logic chip_select_n,
    output logic spi_clk,
    output logic spi_mosi,
    input wire logic spi_miso_q
);
    // each phase is held above the 4-cycle minimum the sampler needs
    localparam int HALF = 5;
    // idle bus: deselected, clock parked low
    initial begin
        chip_select_n = 1'b1;
        spi_clk = 1'b0;
        spi_mosi = 1'b0;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wait_cyc
    // one frame, msb first; nbits below 16 gives a truncated frame
    task automatic xfer(input logic [15:0] word, input int nbits,
        output logic [7:0] rd);
        rd = 8'h00;
        @(posedge ref_clk);
        chip_select_n <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            spi_mosi <= word[15 - i];
            wait_cyc(HALF);
            if (i >= 8)
                rd[15 - i] = spi_miso_q;
            spi_clk <= 1'b1;
            wait_cyc(HALF);
            spi_clk <= 1'b0;
        end
        wait_cyc(HALF);
        chip_select_n <= 1'b1;
        // released data line must not keep looking valid
        spi_mosi <= ~spi_mosi;
        wait_cyc(8);
    endtask : xfer
endmodule : bwc_spi_master

//--- bwc_regs_tb.sv
// self-checking bench of the bus and wake control registers
`timescale 1ns/1ps
`include "bwc_defs.svh"
module bwc_regs_tb
    import bwc_pkg::*;
;
    logic ref_clk, reset_n, chip_select_n, spi_clk, spi_mosi;
    logic soft_reset, failsafe_entry, restart_entry, hw_load;
    logic spi_miso_q, spi_miso_oe_n_q, slope_control_on_q;
    logic low_slope_select_q, transmit_timeout_enable_q;
    logic peak_threshold_high_q, timer_one_wake_enable_q;
    logic timer_two_wake_enable_q, stop_watchdog_off_hi_q;
    logic ext_wake_failsafe_q;
    bwc_sbc_mode_t sbc_mode;
    bwc_hw_upd_t hw_upd;
    bwc_xcvr_t can_mode_q, first_lin_mode_q, second_lin_mode_q;
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    // device under test
    bwc_regs DUT (.ref_clk(ref_clk), .reset_n(reset_n),
        .chip_select_n(chip_select_n), .spi_clk(spi_clk),
        .spi_mosi(spi_mosi), .spi_miso_q(spi_miso_q),
        .spi_miso_oe_n_q(spi_miso_oe_n_q), .sbc_mode(sbc_mode),
        .soft_reset(soft_reset), .failsafe_entry(failsafe_entry),
        .restart_entry(restart_entry), .hw_load(hw_load),
        .hw_upd(hw_upd), .can_mode_q(can_mode_q),
        .first_lin_mode_q(first_lin_mode_q),
        .second_lin_mode_q(second_lin_mode_q),
        .slope_control_on_q(slope_control_on_q),
        .low_slope_select_q(low_slope_select_q),
        .transmit_timeout_enable_q(transmit_timeout_enable_q),
        .peak_threshold_high_q(peak_threshold_high_q),
        .timer_one_wake_enable_q(timer_one_wake_enable_q),
        .timer_two_wake_enable_q(timer_two_wake_enable_q),
        .stop_watchdog_off_hi_q(stop_watchdog_off_hi_q),
        .ext_wake_failsafe_q(ext_wake_failsafe_q));
    // microcontroller side of the SPI link
    bwc_spi_master u_mst (.ref_clk(ref_clk), .chip_select_n(chip_select_n),
        .spi_clk(spi_clk), .spi_mosi(spi_mosi), .spi_miso_q(spi_miso_q));
    always #5 ref_clk = ~ref_clk;
    // hang guard, about three and a half times the expected run
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (fails == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_mode(input bwc_xcvr_t got, input logic [1:0] c);
        bwc_xcvr_t e;
        e = {c == 2'h0, c == 2'h1, c == 2'h2, c == 2'h3};
        chk({4'h0, got}, {4'h0, e});
    endtask : chk_mode
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_mst.xfer({1'b1, a, d}, 16, r);
    endtask : wr
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] r;
        u_mst.xfer({1'b0, a, 8'h00}, 16, r);
        chk(r, e);
    endtask : rchk
    // one-cycle control strobe; counts external wake reload pulses
    task automatic strobe(input logic [3:0] v, output int n);
        n = 0;
        @(posedge ref_clk);
        {soft_reset, failsafe_entry, restart_entry, hw_load} <= v;
        @(posedge ref_clk);
        {soft_reset, failsafe_entry, restart_entry, hw_load} <= 4'h0;
        repeat (4) begin
            @(negedge ref_clk);
            n += ext_wake_failsafe_q;
        end
    endtask : strobe
    task automatic t_zero();
        rchk(`BWC_ADDR_BUS1, 8'h00);
        rchk(`BWC_ADDR_BUS2, 8'h00);
        rchk(`BWC_ADDR_WAKE, 8'h00);
        chk_mode(can_mode_q, 2'h0);
        chk({6'h0, slope_control_on_q, spi_miso_oe_n_q}, 8'h03);
    endtask : t_zero
    task automatic t_bus1();
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            d = {i[0], ~i[0], i[1], i[1:0], 1'b1, ~i[1:0]};
            wr(`BWC_ADDR_BUS1, d);
            rchk(`BWC_ADDR_BUS1, d & 8'hFB);
            chk({5'h0, slope_control_on_q, low_slope_select_q,
                transmit_timeout_enable_q}, {5'h0, ~d[7], d[6:5]});
            chk_mode(first_lin_mode_q, d[4:3]);
            chk_mode(can_mode_q, d[1:0]);
        end
    endtask : t_bus1
    // peak bit only moves in init or normal, second_lin_mode field always
    task automatic t_bus2();
        logic [7:0] d;
        logic p;
        wr(`BWC_ADDR_BUS2, 8'h20);
        p = 1'b1;
        for (int m = 0; m < 6; m++) begin
            @(posedge ref_clk);
            sbc_mode <= bwc_sbc_mode_t'(m);
            d = {2'b11, m == 1, 3'b111, m[1:0]};
            wr(`BWC_ADDR_BUS2, d);
            if (m < 2)
                p = d[5];
            rchk(`BWC_ADDR_BUS2, {2'b00, p, 3'b000, m[1:0]});
            chk({7'h0, peak_threshold_high_q}, {7'h0, p});
            chk_mode(second_lin_mode_q, m[1:0]);
        end
        @(posedge ref_clk);
        sbc_mode <= BWC_NORMAL;
    endtask : t_bus2
    task automatic t_wake();
        logic [7:0] wv [4] = '{8'hFF, 8'h40, 8'h84, 8'h3B};
        for (int i = 0; i < 4; i++) begin
            wr(`BWC_ADDR_WAKE, wv[i]);
            rchk(`BWC_ADDR_WAKE, wv[i] & 8'hC4);
            chk({5'h0, timer_two_wake_enable_q, timer_one_wake_enable_q,
                stop_watchdog_off_hi_q}, {5'h0, wv[i][7:6], wv[i][2]});
        end
    endtask : t_wake
    // unmapped address and a 15-bit frame both leave no trace
    task automatic t_refuse();
        logic [7:0] r;
        wr(`BWC_ADDR_BUS1, 8'h48);
        wr(7'h10, 8'hFF);
        rchk(7'h10, 8'h00);
        u_mst.xfer({1'b1, `BWC_ADDR_BUS1, 8'hB3}, 15, r);
        rchk(`BWC_ADDR_BUS1, 8'h48);
    endtask : t_refuse
    task automatic t_reloads();
        int n;
        wr(`BWC_ADDR_BUS1, 8'hFF);
        wr(`BWC_ADDR_BUS2, 8'hFF);
        wr(`BWC_ADDR_WAKE, 8'hC4);
        strobe(4'h4, n);
        chk(8'(n), 8'h01);
        rchk(`BWC_ADDR_BUS1, 8'hE9);
        rchk(`BWC_ADDR_BUS2, 8'h01);
        chk_mode(can_mode_q, 2'h1);
        chk_mode(second_lin_mode_q, 2'h1);
        wr(`BWC_ADDR_BUS2, 8'h23);
        strobe(4'h2, n);
        rchk(`BWC_ADDR_WAKE, 8'hC0);
        chk({5'h0, timer_two_wake_enable_q, timer_one_wake_enable_q,
            stop_watchdog_off_hi_q}, 8'h06);
        @(posedge ref_clk);
        hw_upd <= 7'h4F;
        strobe(4'h1, n);
        rchk(`BWC_ADDR_BUS1, 8'hEA);
        rchk(`BWC_ADDR_WAKE, 8'hC4);
        chk_mode(first_lin_mode_q, 2'h1);
        chk_mode(second_lin_mode_q, 2'h3);
        strobe(4'h8, n);
        t_zero();
    endtask : t_reloads
    initial begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        {soft_reset, failsafe_entry, restart_entry, hw_load} = 4'h0;
        sbc_mode = BWC_NORMAL;
        hw_upd = 7'h00;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_zero();
        t_bus1();
        t_bus2();
        t_wake();
        t_refuse();
        t_reloads();
        end_sim();
    end
endmodule : bwc_regs_tb
